// ==== bench/cam_engine_model.sv ====
// Protocol engine model that hands received identifiers
`timescale 1ns/1ps
module cam_engine_model (input wire logic ref_clk, output cam_pkg::cam_frame_s rxFrame);
  initial rxFrame = '0;
  task automatic send(input logic ext, input logic [28:0] id);
    rxFrame <= {1'b1, ext, id};
    @(posedge ref_clk);
    rxFrame <= {1'b0, ~ext, ~id};
  endtask
endmodule

// ==== bench/cam_mask_assertions.sv ====
// Assertions on the acceptance mask block ports
`timescale 1ns/1ps
module cam_mask_assertions (input wire logic ref_clk, rst, psel, penable, pwrite,
  input wire logic [11:0] paddr, input wire logic [31:0] pwdata, prdata,
  input wire logic pready, pslverr, matchValid, filter8Hit, input wire cam_pkg::cam_frame_s rxFrame);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_ready_setup: assert property (psel && !penable |=> pready && penable) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_err_zero: assert property (pslverr |-> pready && (pwrite || prdata == 0)) else $error("bad error");
  a_match_next: assert property (rxFrame.valid |=> matchValid) else $error("no match");
  a_match_cause: assert property (matchValid |-> $past(rxFrame.valid)) else $error("stray match");
  a_hit_gated: assert property (filter8Hit |-> matchValid) else $error("stray hit");
  a_std_gaps: assert property (pready && !pwrite && paddr inside {12'h004, 12'h00c, 12'h014}
    |-> !prdata[4] && !prdata[2]) else $error("gap bits set");
  a_upper_zero: assert property (pready && !pwrite && paddr < 12'h01c |-> prdata[31:16] == 0)
    else $error("upper bits set");
  cover property (filter8Hit);
  cover property (matchValid && !filter8Hit);
  cover property (pslverr);
endmodule

// ==== bench/cam_mask_test.sv ====
// Self-checking bench of the acceptance mask block
`timescale 1ns/1ps
module cam_mask_test;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, matchValid, filter8Hit, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  cam_pkg::cam_frame_s rxFrame;
  localparam logic [28:0] F = 29'h16940000;
  logic [75:0] rows [7] = '{{12'h000, 32'hffffffff, 32'h0000ffff}, {12'h004, 32'hffffffff, 32'h0000ffeb},
    {12'h008, 32'hffffffff, 32'h0000ffff}, {12'h00c, 32'h12345678, 32'h00005668},
    {12'h010, 32'h0000abcd, 32'h0000abcd}, {12'h014, 32'h0, 32'h0}, {12'h018, 32'h0, 32'h0}};
  logic [43:0] cfg [7] = '{{12'h004, 32'hffe1}, {12'h008, 32'h0}, {12'h00c, 32'h0}, {12'h010, 32'h0},
    {12'h014, 32'h8}, {12'h018, 32'h0}, {12'h01c, 32'h16940000}};
  logic [15:0] hits = 16'hafd0;
  int fails = 0, check_count = 0;
  always #12.5 ref_clk = ~ref_clk;
  cam_mask dut (.*);
  cam_engine_model eng (.ref_clk(ref_clk), .rxFrame(rxFrame));
  task automatic results();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok);
    check_count++;
    if (!ok) begin
      fails++;
      $display("mismatch %0t wrong value", $time);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (pready !== 1 && n < 20);
    if (n >= 20) begin fails++; results(); end
    q = prdata; e = pslverr; psel <= 0; penable <= 0;
    @(posedge ref_clk);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    apb(0, 12'h000, 0); chk(q === 32'h0);
    foreach (rows[i]) begin
      apb(1, rows[i][75:64], rows[i][63:32]);
      apb(0, rows[i][75:64], 0); chk(q === rows[i][31:0] && e === 0);
    end
    apb(1, 12'h200, 32'hffffffff);
    apb(0, 12'h200, 0); chk(q === 0 && e === 1);
    foreach (cfg[i]) apb(1, cfg[i][43:32], cfg[i][31:0]);
    for (int s = 0; s < 4; s++) begin
      apb(1, 12'h000, s);
      for (int f = 0; f < 4; f++) begin
        eng.send(f == 2, f == 1 ? F ^ (29'h1 << 28) : f == 3 ? F ^ (29'h1 << 16) : F);
        @(posedge ref_clk);
        chk(matchValid === 1 && filter8Hit === hits[15 - s * 4 - f]);
      end
    end
    apb(0, 12'h01c, 0); chk(q === 32'h16940000 && e === 0);
    rst <= 1;
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    apb(0, 12'h000, 0); chk(q === 32'h0);
    apb(0, 12'h014, 0); chk(q === 32'h8);
    results();
  end
endmodule
bind cam_mask cam_mask_assertions chk_i (.*);

// ==== hdl/cam_mask.sv ====
// CAN acceptance mask registers and filter 8 masked comparison
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "cam_regs.svh"
module cam_mask (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cam_pkg::cam_frame_s rxFrame,
  output logic matchValid,
  output logic filter8Hit
);
  logic [15:0] selHigh_r;
  cam_pkg::cam_mask_s masks_r [3];
  logic [29:0] filter_r;
  logic [31:0] result_r;
  logic access;
  logic setup;
  logic mapped;
  logic [31:0] rdMux;
  logic wrEn;
  logic wrSel;
  logic wrFilter;
  logic [2:0] wrStd;
  logic [2:0] wrExt;
  logic idMatch;

  // Gathers the 29 mask bits laid out as standard then extended
  function automatic logic [28:0] fullMask(input cam_pkg::cam_mask_s m);
    fullMask = {m.std[`CAM_STD_SID_HI:`CAM_STD_SID_LO], m.std[1:0], m.ext};
  endfunction

  // Standard mask as software sees it, unimplemented bits zero
  function automatic logic [31:0] stdView(input cam_pkg::cam_mask_s m);
    stdView = {16'h0000, m.std & `CAM_STD_WMASK};
  endfunction

  function automatic logic isReg(input logic [11:0] addr, input logic [11:0] off);
    isReg = (addr == off);
  endfunction

  assign access = psel & penable;
  assign setup = psel & ~penable;
  // Writes land only in the access cycle that carries pready
  assign wrEn = access & pready & pwrite;

  // Write strobes, one per writable register
  always_comb begin
    wrSel = 1'b0;
    wrFilter = 1'b0;
    wrStd = 3'b000;
    wrExt = 3'b000;
    if (wrEn) begin
      wrSel = isReg(paddr, `CAM_OFF_SEL_HIGH);
      wrFilter = isReg(paddr, `CAM_OFF_FILTER);
      wrStd[0] = isReg(paddr, `CAM_OFF_STD0);
      wrStd[1] = isReg(paddr, `CAM_OFF_STD1);
      wrStd[2] = isReg(paddr, `CAM_OFF_STD2);
      wrExt[0] = isReg(paddr, `CAM_OFF_EXT0);
      wrExt[1] = isReg(paddr, `CAM_OFF_EXT1);
      wrExt[2] = isReg(paddr, `CAM_OFF_EXT2);
    end
  end

  // Read mux; unmapped addresses answer with an error
  always_comb begin
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    case (paddr)
      `CAM_OFF_SEL_HIGH: begin
        rdMux = {16'h0000, selHigh_r};
      end
      `CAM_OFF_STD0: begin
        rdMux = stdView(masks_r[0]);
      end
      `CAM_OFF_EXT0: begin
        rdMux = {16'h0000, masks_r[0].ext};
      end
      `CAM_OFF_STD1: begin
        rdMux = stdView(masks_r[1]);
      end
      `CAM_OFF_EXT1: begin
        rdMux = {16'h0000, masks_r[1].ext};
      end
      `CAM_OFF_STD2: begin
        rdMux = stdView(masks_r[2]);
      end
      `CAM_OFF_EXT2: begin
        rdMux = {16'h0000, masks_r[2].ext};
      end
      `CAM_OFF_FILTER: begin
        rdMux = {2'b00, filter_r};
      end
      `CAM_OFF_RESULT: begin
        rdMux = result_r;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Bus answer: zero wait states, ready one cycle after setup
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
    end
  end

  // Read data held until the next read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      prdata <= rdMux;
    end
  end

  // Upper selector bits; bits 1:0 pick the mask for filter 8, the rest are stored for the other filters
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      selHigh_r <= `CAM_SEL_RESET;
    end else if (wrSel) begin
      selHigh_r <= pwdata[15:0];
    end
  end

  // Reference identifier and its extended-enable bit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      filter_r <= 30'h0000_0000;
    end else if (wrFilter) begin
      filter_r <= pwdata[29:0];
    end
  end

  // No reset on masks
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (wrStd[i]) begin
        masks_r[i].std <= pwdata[15:0] & `CAM_STD_WMASK;
      end
      if (wrExt[i]) begin
        masks_r[i].ext <= pwdata[15:0];
      end
    end
  end

  logic [1:0] src;
  logic srcOk;
  cam_pkg::cam_mask_s selMask;
  logic [28:0] cmpMask;
  logic typeOk;
  logic hitNxt;

  assign src = selHigh_r[1:0];

  // Reserved code selects no mask, so nothing matches
  always_comb begin
    srcOk = 1'b1;
    selMask = masks_r[0];
    case (cam_pkg::cam_src_e'(src))
      cam_pkg::CAM_SRC_MASK0: begin
        selMask = masks_r[0];
      end
      cam_pkg::CAM_SRC_MASK1: begin
        selMask = masks_r[1];
      end
      cam_pkg::CAM_SRC_MASK2: begin
        selMask = masks_r[2];
      end
      default: begin
        srcOk = 1'b0;
      end
    endcase
  end

  // Frame type only matters when the mask asks for it
  always_comb begin
    cmpMask = fullMask(selMask);
    typeOk = ~selMask.std[`CAM_STD_TYPE_BIT] | (rxFrame.ext == filter_r[`CAM_FLT_EXT_BIT]);
    idMatch = (((rxFrame.ident ^ filter_r[28:0]) & cmpMask) == 29'h0000_0000);
    hitNxt = srcOk & typeOk & idMatch;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      matchValid <= 1'b0;
      filter8Hit <= 1'b0;
    end else begin
      matchValid <= rxFrame.valid;
      filter8Hit <= rxFrame.valid & hitNxt;
    end
  end

  // Result: bit 1 last frame type, bit 0 last hit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      result_r <= 32'h0000_0000;
    end else if (rxFrame.valid) begin
      result_r <= {30'h0000_0000, rxFrame.ext, hitNxt};
    end
  end
endmodule

// ==== hdl/cam_pkg.sv ====
// Types of the acceptance mask block
package cam_pkg;
  typedef enum logic [1:0] {
    CAM_SRC_MASK0,
    CAM_SRC_MASK1,
    CAM_SRC_MASK2,
    CAM_SRC_RSVD
  } cam_src_e;
  typedef struct packed {
    logic [15:0] std;
    logic [15:0] ext;
  } cam_mask_s;
  typedef struct packed {
    logic valid;
    logic ext;
    logic [28:0] ident;
  } cam_frame_s;
endpackage

// ==== hdl/cam_regs.svh ====
// Register offsets, field positions and reset values of the acceptance mask block
`ifndef CAM_REGS_SVH
`define CAM_REGS_SVH
`define CAM_OFF_SEL_HIGH 12'h000
`define CAM_OFF_STD0 12'h004
`define CAM_OFF_EXT0 12'h008
`define CAM_OFF_STD1 12'h00c
`define CAM_OFF_EXT1 12'h010
`define CAM_OFF_STD2 12'h014
`define CAM_OFF_EXT2 12'h018
`define CAM_OFF_FILTER 12'h01c
`define CAM_OFF_RESULT 12'h020
`define CAM_SEL_RESET 16'h0000
`define CAM_STD_WMASK 16'hffeb
`define CAM_STD_SID_HI 15
`define CAM_STD_SID_LO 5
`define CAM_STD_TYPE_BIT 3
`define CAM_FLT_EXT_BIT 29
`endif
